// ===== uart_sb_pkg.sv
// Purpose: Shared constants and types for the stop-bit checker and baud generator
// Assumes: AXI4-Lite word registers, one clock, synchronous active-high reset
// Notes:   Offsets and field positions below are fixed for this block
//
// Contract
// [RULE1] Stop length: 1, 2, or smartcard 0.5, 1.5
// [RULE2] Half stop: no sampling, no framing/break
// [RULE3] One stop: samples 8, 9, 10
// [RULE4] Software keeps receiver enabled in smartcard transmit
// [RULE5] 1.5 stop low: framing error with not-empty
// [RULE6] 1.5 stop: samples 16, 17, 18
// [RULE7] Two stops: first checked on 8, 9, 10
// [RULE8] Two stops: second unchecked, not-empty after first
// [RULE9] Transmit and receive share one bit rate
// [RULE10] Standard rate: clock/(8*(2-oversample)*divisor)
// [RULE11] Smartcard/LIN/infrared rate: clock/(16*divisor)
// [RULE12] Divisor held as mantissa plus fraction
// [RULE13] Sixteen-times oversampling: four-bit fraction
// [RULE14] Eight-times: three-bit fraction, top bit cleared
// [RULE15] Divisor write reloads counters; avoid while active
// [RULE16] Software carries fraction overflow into mantissa
// [RULE17] Oversample select: clear 16x, set 8x
// [RULE18] Oversample select forced clear in special modes
// [RULE19] Fraction low four bits, mantissa from bit four
// [RULE20] Tick spacing averages the fixed-point divisor
`default_nettype none
package uart_sb_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_DATA   = 8'h04;
  localparam logic [7:0] ADDR_BAUD   = 8'h08;
  localparam logic [7:0] ADDR_CTRL1  = 8'h0c;
  localparam logic [7:0] ADDR_CTRL2  = 8'h10;

  // ==========================================================================
  // Field positions
  localparam int FRAC_POS   = 0;
  localparam int FRAC_W     = 4;
  localparam int MANT_POS   = 4;
  localparam int MANT_W     = 12;
  localparam int UE_POS     = 13;
  localparam int RE_POS     = 2;
  localparam int TE_POS     = 3;
  localparam int OVS_POS    = 15;
  localparam int IR_POS     = 1;
  localparam int SC_POS     = 5;
  localparam int STOP_POS   = 12;
  localparam int LIN_POS    = 14;
  localparam int FE_POS     = 1;
  localparam int RECEIVE_NOT_EMPTY_FLAG_POS   = 5;
  localparam int TXBUSY_POS = 7;
  localparam int BRK_POS    = 8;
  localparam int RXBUSY_POS = 9;

  // ==========================================================================
  // Reset values and counts
  localparam logic [15:0] BAUD_RST  = 16'h0000;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [4:0]  SPB_X16   = 5'h10;
  localparam logic [4:0]  SPB_X8    = 5'h08;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;

  typedef enum logic [1:0] {
    STOP_ONE      = 2'h0,
    STOP_HALF     = 2'h1,
    STOP_TWO      = 2'h2,
    STOP_ONE_HALF = 2'h3
  } stop_sel_type;

  typedef struct packed {
    logic [MANT_W-1:0] mant;
    logic [FRAC_W-1:0] frac;
    logic              oversample_select;
    logic              load;
    logic              run;
  } baud_cfg_type;

  typedef struct packed {
    logic         enable;
    logic         rx_en;
    logic         tx_en;
    logic         oversample_select;
    stop_sel_type stop;
  } cfg_type;

endpackage
`default_nettype wire

// ===== uart_baud_tick.sv
// Purpose: Fractional oversampling tick generator shared by receive and transmit
// Assumes: Divisor counts clock cycles between oversampling ticks
// Notes:   Mantissa of zero behaves as one
`timescale 1ns/1ns
`default_nettype none
module uart_baud_tick
  import uart_sb_pkg::*;
(
  input  wire logic         i_clock, // System clock
  input  wire logic         i_srst,  // Synchronous reset
  input  wire baud_cfg_type i_cfg,   // Divisor and control
  output var  logic         o_tick   // Oversampling tick pulse
);

  logic [MANT_W-1:0] cnt_ff;
  logic [MANT_W-1:0] nxt_cnt;
  logic [3:0]        acc_ff;
  logic [3:0]        nxt_acc;
  logic              nxt_tick;
  logic [4:0]        step;
  logic [4:0]        sum;
  logic [MANT_W-1:0] period;

  // ==========================================================================
  // Next state
  always_comb begin
    // Eighths become sixteenths; fraction top bit ignored in 8x  [RULE14]
    step = i_cfg.oversample_select ? {1'b0, i_cfg.frac[2:0], 1'b0}
                       : {1'b0, i_cfg.frac};                      // [RULE13]
    sum = {1'b0, acc_ff} + step;
    period = (i_cfg.mant == '0) ? MANT_W'(1) : i_cfg.mant;        // [RULE12]
    nxt_tick = 1'b0;
    nxt_acc = acc_ff;
    nxt_cnt = cnt_ff;
    if (i_cfg.load || !i_cfg.run) begin
      nxt_cnt = period - MANT_W'(1);                             // [RULE15]
      nxt_acc = '0;
    end else if (cnt_ff == '0) begin
      // Carry adds one cycle so spacing averages mantissa+fraction
      nxt_tick = 1'b1;
      nxt_acc = sum[3:0];
      nxt_cnt = period - MANT_W'(1) + MANT_W'(sum[4]);           // [RULE20]
    end else begin
      nxt_cnt = cnt_ff - MANT_W'(1);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cnt_ff <= '0;
      acc_ff <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      acc_ff <= nxt_acc;
      o_tick <= nxt_tick;
    end
  end

endmodule
`default_nettype wire

// ===== uart_stop_bits_baud_gen.sv
// Purpose: Serial transceiver with stop-bit checking and fractional baud rate
// Assumes: AXI4-Lite register access, line inputs synchronous to i_clock
// Notes:   Reading the data register clears not-empty, framing and break flags
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module uart_stop_bits_baud_gen
  import uart_sb_pkg::*;
#(
  parameter int DATA_BITS = 8
) (
  input  wire logic        i_clock,   // System clock
  input  wire logic        i_srst,    // Synchronous reset
  input  wire logic        i_awvalid, // Write address valid
  output var  logic        o_awready, // Write address ready
  input  wire logic [7:0]  i_awaddr,  // Write address
  input  wire logic        i_wvalid,  // Write data valid
  output var  logic        o_wready,  // Write data ready
  input  wire logic [31:0] i_wdata,   // Write data
  input  wire logic [3:0]  i_wstrb,   // Write byte strobes
  output var  logic        o_bvalid,  // Write response valid
  input  wire logic        i_bready,  // Write response ready
  output var  logic [1:0]  o_bresp,   // Write response
  input  wire logic        i_arvalid, // Read address valid
  output var  logic        o_arready, // Read address ready
  input  wire logic [7:0]  i_araddr,  // Read address
  output var  logic        o_rvalid,  // Read data valid
  input  wire logic        i_rready,  // Read data ready
  output var  logic [31:0] o_rdata,   // Read data
  output var  logic [1:0]  o_rresp,   // Read response
  input  wire logic        i_rx_line, // Serial receive line
  output var  logic        o_tx_line  // Serial transmit line
);

  if (DATA_BITS < 2 || DATA_BITS > 16) begin : g_bad_width
    $error("DATA_BITS must lie in 2..16");
  end

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_type;

  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = strb[b] ? d[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // ==========================================================================
  // Bus slave state
  logic        awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic        bvalid_ff, nxt_bvalid, arready_ff, nxt_arready;
  logic        rvalid_ff, nxt_rvalid;
  logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [7:0]  awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [3:0]  wstrb_ff, nxt_wstrb;
  logic        wr_fire, rd_fire, rd_hit;
  logic [31:0] rd_word;

  // Register state
  logic [15:0] baud_ff, nxt_baud;
  logic [31:0] ctrl1_ff, nxt_ctrl1, ctrl2_ff, nxt_ctrl2;
  logic        load_ff, nxt_load;
  logic        receive_not_empty_flag_ff, nxt_receive_not_empty_flag, fe_ff, nxt_fe, brk_ff, nxt_brk;
  logic [DATA_BITS-1:0] rdr_ff, nxt_rdr;

  // Receiver state
  rx_state_type         rx_state_ff, nxt_rx_state;
  logic [4:0]           rx_cnt_ff, nxt_rx_cnt;
  logic [3:0]           rx_bit_ff, nxt_rx_bit;
  logic [2:0]           rx_smp_ff, nxt_rx_smp;
  logic [DATA_BITS-1:0] rx_sh_ff, nxt_rx_sh;
  logic                 rx_done, rx_fe, rx_brk;

  // Transmitter state
  tx_state_type         tx_state_ff, nxt_tx_state;
  logic [4:0]           tx_cnt_ff, nxt_tx_cnt;
  logic [3:0]           tx_bit_ff, nxt_tx_bit;
  logic [DATA_BITS-1:0] tx_sh_ff, nxt_tx_sh;
  logic                 tx_line_ff, nxt_tx_line;

  // Shared timing
  cfg_type      cfg;
  baud_cfg_type bcfg;
  logic         tick, special;
  logic [4:0]   spb, half, lo, rx_end, tx_end;
  logic         in_win, dat_win, tx_go;

  // ==========================================================================
  // Configuration and baud generator
  always_comb begin
    special = ctrl2_ff[SC_POS] | ctrl2_ff[IR_POS] | ctrl2_ff[LIN_POS];
    cfg.enable = ctrl1_ff[UE_POS];
    cfg.rx_en = ctrl1_ff[RE_POS];
    cfg.tx_en = ctrl1_ff[TE_POS];
    cfg.oversample_select = ctrl1_ff[OVS_POS] & ~special;                    // [RULE18] [RULE11]
    cfg.stop = stop_sel_type'(ctrl2_ff[STOP_POS +: 2]);          // [RULE1]
    bcfg.mant = baud_ff[MANT_POS +: MANT_W];                     // [RULE19]
    bcfg.frac = baud_ff[FRAC_POS +: FRAC_W];
    bcfg.oversample_select = cfg.oversample_select;
    bcfg.load = load_ff;
    bcfg.run = cfg.enable;
    spb = cfg.oversample_select ? SPB_X8 : SPB_X16;                          // [RULE17] [RULE10]
    half = spb >> 1;
  end

  // One tick stream clocks both directions
  uart_baud_tick u_tick (                                        // [RULE9]
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_cfg   (bcfg),
    .o_tick  (tick)
  );

  // ==========================================================================
  // AXI4-Lite slave
  always_comb begin
    nxt_awready = awready_ff;
    nxt_wready = wready_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_arready = arready_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    wr_fire = !awready_ff && !wready_ff && !bvalid_ff;
    rd_fire = i_arvalid && arready_ff;
    rd_hit = 1'b1;
    unique case (i_araddr)
      ADDR_STATUS: rd_word = 32'((receive_not_empty_flag_ff << RECEIVE_NOT_EMPTY_FLAG_POS) | (fe_ff << FE_POS)
                             | (brk_ff << BRK_POS) | ((tx_state_ff != TX_IDLE) << TXBUSY_POS)
                             | ((rx_state_ff != RX_IDLE) << RXBUSY_POS));
      ADDR_DATA:   rd_word = 32'(rdr_ff);
      ADDR_BAUD:   rd_word = 32'(baud_ff);
      ADDR_CTRL1:  rd_word = ctrl1_ff;
      ADDR_CTRL2:  rd_word = ctrl2_ff;
      default: begin
        rd_word = '0;
        rd_hit = 1'b0;
      end
    endcase
    if (i_awvalid && awready_ff) begin
      nxt_awready = 1'b0;
      nxt_awaddr = i_awaddr;
    end
    if (i_wvalid && wready_ff) begin
      nxt_wready = 1'b0;
      nxt_wdata = i_wdata;
      nxt_wstrb = i_wstrb;
    end
    if (wr_fire) begin
      nxt_bvalid = 1'b1;
      nxt_bresp = (awaddr_ff inside {ADDR_STATUS, ADDR_DATA, ADDR_BAUD, ADDR_CTRL1,
                                     ADDR_CTRL2}) ? RESP_OK : RESP_ERR;
    end
    if (bvalid_ff && i_bready) begin
      nxt_bvalid = 1'b0;
      nxt_awready = 1'b1;
      nxt_wready = 1'b1;
    end
    if (rd_fire) begin
      nxt_arready = 1'b0;
      nxt_rvalid = 1'b1;
      nxt_rdata = rd_word;
      nxt_rresp = rd_hit ? RESP_OK : RESP_ERR;
    end
    if (rvalid_ff && i_rready) begin
      nxt_rvalid = 1'b0;
      nxt_arready = 1'b1;
    end
  end

  // ==========================================================================
  // Registers and flags
  always_comb begin
    nxt_baud = baud_ff;
    nxt_ctrl1 = ctrl1_ff;
    nxt_ctrl2 = ctrl2_ff;
    nxt_load = 1'b0;
    nxt_receive_not_empty_flag = receive_not_empty_flag_ff;
    nxt_fe = fe_ff;
    nxt_brk = brk_ff;
    nxt_rdr = rdr_ff;
    tx_go = 1'b0;
    if (wr_fire) begin
      unique case (awaddr_ff)
        ADDR_BAUD: begin
          nxt_baud = 16'(merge(32'(baud_ff), wdata_ff, wstrb_ff));
          nxt_load = 1'b1;                                       // [RULE15]
        end
        ADDR_CTRL1: nxt_ctrl1 = merge(ctrl1_ff, wdata_ff, wstrb_ff);
        ADDR_CTRL2: nxt_ctrl2 = merge(ctrl2_ff, wdata_ff, wstrb_ff);
        ADDR_DATA:  tx_go = wstrb_ff[0];
        ADDR_STATUS: begin
          if (wstrb_ff[0] && !wdata_ff[RECEIVE_NOT_EMPTY_FLAG_POS]) begin
            nxt_receive_not_empty_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (rd_fire && i_araddr == ADDR_DATA) begin
      nxt_receive_not_empty_flag = 1'b0;
      nxt_fe = 1'b0;
      nxt_brk = 1'b0;
    end
    // A completing frame wins over a same-cycle clear
    if (rx_done) begin
      nxt_receive_not_empty_flag = 1'b1;                                           // [RULE5] [RULE8]
      nxt_fe = rx_fe;
      nxt_brk = rx_brk;
      nxt_rdr = rx_sh_ff;
    end
  end

  // ==========================================================================
  // Receiver
  always_comb begin
    nxt_rx_state = rx_state_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_smp = rx_smp_ff;
    nxt_rx_sh = rx_sh_ff;
    rx_done = 1'b0;
    rx_fe = 1'b0;
    rx_brk = 1'b0;
    // Stop window at 16x: 8th-10th normally, 16th-18th for one and a half
    lo = (cfg.stop == STOP_ONE_HALF) ? spb - 5'h01 : half - 5'h01; // [RULE6] [RULE3] [RULE7]
    unique case (cfg.stop)
      STOP_HALF:     rx_end = half - 5'h01;
      STOP_ONE_HALF: rx_end = spb + half - 5'h01;                // [RULE6]
      default:       rx_end = spb - 5'h01;                       // [RULE8]
    endcase
    dat_win = rx_cnt_ff >= half - 5'h01 && rx_cnt_ff <= half + 5'h01;
    in_win = rx_cnt_ff >= lo && rx_cnt_ff <= lo + 5'h02;
    if (!(cfg.enable && cfg.rx_en)) begin
      nxt_rx_state = RX_IDLE;
    end else if (tick) begin
      nxt_rx_cnt = rx_cnt_ff + 5'h01;
      unique case (rx_state_ff)
        RX_IDLE: begin
          nxt_rx_cnt = '0;
          if (!i_rx_line) begin
            nxt_rx_state = RX_START;
            nxt_rx_cnt = 5'h01;
          end
        end
        RX_START: begin
          if (dat_win) nxt_rx_smp = {rx_smp_ff[1:0], i_rx_line};
          if (rx_cnt_ff == spb - 5'h01) begin
            nxt_rx_cnt = '0;
            nxt_rx_bit = '0;
            nxt_rx_state = maj3(rx_smp_ff) ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (dat_win) nxt_rx_smp = {rx_smp_ff[1:0], i_rx_line};
          if (rx_cnt_ff == spb - 5'h01) begin
            nxt_rx_cnt = '0;
            nxt_rx_sh = {maj3(rx_smp_ff), rx_sh_ff[DATA_BITS-1:1]};
            nxt_rx_bit = rx_bit_ff + 4'h1;
            if (rx_bit_ff == 4'(DATA_BITS - 1)) nxt_rx_state = RX_STOP;
          end
        end
        RX_STOP: begin
          if (in_win && cfg.stop != STOP_HALF) begin
            nxt_rx_smp = {rx_smp_ff[1:0], i_rx_line};
          end
          if (rx_cnt_ff == rx_end) begin
            rx_done = 1'b1;
            // Half stop is never sampled
            rx_fe = (cfg.stop != STOP_HALF) && !maj3(rx_smp_ff); // [RULE2] [RULE5]
            rx_brk = rx_fe && rx_sh_ff == '0;                    // [RULE2]
            nxt_rx_state = RX_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Transmitter
  always_comb begin
    nxt_tx_state = tx_state_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_sh = tx_sh_ff;
    unique case (cfg.stop)
      STOP_HALF:     tx_end = half - 5'h01;
      STOP_TWO:      tx_end = 5'({1'b0, spb} + {1'b0, spb} - 6'h01);
      STOP_ONE_HALF: tx_end = spb + half - 5'h01;
      default:       tx_end = spb - 5'h01;
    endcase
    if (!cfg.enable) begin
      nxt_tx_state = TX_IDLE;
    end else if (tx_state_ff == TX_IDLE) begin
      if (tx_go && cfg.tx_en) begin
        nxt_tx_state = TX_START;
        nxt_tx_sh = wdata_ff[DATA_BITS-1:0];
        nxt_tx_cnt = '0;
        nxt_tx_bit = '0;
      end
    end else if (tick) begin
      nxt_tx_cnt = tx_cnt_ff + 5'h01;
      unique case (tx_state_ff)
        TX_START: begin
          if (tx_cnt_ff == spb - 5'h01) begin
            nxt_tx_cnt = '0;
            nxt_tx_state = TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_cnt_ff == spb - 5'h01) begin
            nxt_tx_cnt = '0;
            nxt_tx_sh = tx_sh_ff >> 1;
            nxt_tx_bit = tx_bit_ff + 4'h1;
            if (tx_bit_ff == 4'(DATA_BITS - 1)) nxt_tx_state = TX_STOP;
          end
        end
        default: begin
          if (tx_cnt_ff == tx_end) nxt_tx_state = TX_IDLE;
        end
      endcase
    end
    unique case (nxt_tx_state)
      TX_START: nxt_tx_line = 1'b0;
      TX_DATA:  nxt_tx_line = nxt_tx_sh[0];
      default:  nxt_tx_line = 1'b1;
    endcase
  end

  // ==========================================================================
  // State registers
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OK;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OK;
      rdata_ff <= '0;
      baud_ff <= BAUD_RST;
      ctrl1_ff <= CTRL_RST;
      ctrl2_ff <= CTRL_RST;
      load_ff <= 1'b0;
      receive_not_empty_flag_ff <= 1'b0;
      fe_ff <= 1'b0;
      brk_ff <= 1'b0;
      rdr_ff <= '0;
      rx_state_ff <= RX_IDLE;
      rx_cnt_ff <= '0;
      rx_bit_ff <= '0;
      rx_smp_ff <= '0;
      rx_sh_ff <= '0;
      tx_state_ff <= TX_IDLE;
      tx_cnt_ff <= '0;
      tx_bit_ff <= '0;
      tx_sh_ff <= '0;
      tx_line_ff <= 1'b1;
    end else begin
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      baud_ff <= nxt_baud;
      ctrl1_ff <= nxt_ctrl1;
      ctrl2_ff <= nxt_ctrl2;
      load_ff <= nxt_load;
      receive_not_empty_flag_ff <= nxt_receive_not_empty_flag;
      fe_ff <= nxt_fe;
      brk_ff <= nxt_brk;
      rdr_ff <= nxt_rdr;
      rx_state_ff <= nxt_rx_state;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_bit_ff <= nxt_rx_bit;
      rx_smp_ff <= nxt_rx_smp;
      rx_sh_ff <= nxt_rx_sh;
      tx_state_ff <= nxt_tx_state;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_bit_ff <= nxt_tx_bit;
      tx_sh_ff <= nxt_tx_sh;
      tx_line_ff <= nxt_tx_line;
    end
  end

  assign o_awready = awready_ff;
  assign o_wready = wready_ff;
  assign o_bvalid = bvalid_ff;
  assign o_bresp = bresp_ff;
  assign o_arready = arready_ff;
  assign o_rvalid = rvalid_ff;
  assign o_rdata = rdata_ff;
  assign o_rresp = rresp_ff;
  assign o_tx_line = tx_line_ff;

endmodule
`default_nettype wire

// ===== uart_sb_monitor.sv
// Purpose: Port-level checks for the serial block
// Assumes: Sees only top-level ports
// Notes:   Bound into every instance of the top module
`timescale 1ns/1ns
`default_nettype none
module uart_sb_monitor
  import uart_sb_pkg::*;
#(
  parameter int DATA_BITS = 8
) (
  input wire logic        i_clock,   // Clock
  input wire logic        i_srst,    // Reset
  input wire logic        i_awvalid, // AW valid
  input wire logic        o_awready, // AW ready
  input wire logic        i_wvalid,  // W valid
  input wire logic        o_wready,  // W ready
  input wire logic        o_bvalid,  // B valid
  input wire logic        i_bready,  // B ready
  input wire logic [1:0]  o_bresp,   // B response
  input wire logic        i_arvalid, // AR valid
  input wire logic        o_arready, // AR ready
  input wire logic [7:0]  i_araddr,  // AR address
  input wire logic        o_rvalid,  // R valid
  input wire logic        i_rready,  // R ready
  input wire logic [31:0] o_rdata,   // R data
  input wire logic [1:0]  o_rresp,   // R response
  input wire logic        o_tx_line  // Serial out
);
  // ==========
  // Bus and line properties
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  AST_B_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response not held");
  AST_R_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data not held");
  AST_AW_BLOCK: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write accepted while busy");
  AST_R_LAT: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
    else $error("read answer late");
  AST_W_LAT: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[2:3] o_bvalid)
    else $error("write answer late");
  AST_ERR_RD: assert property (i_arvalid && o_arready && i_araddr > ADDR_CTRL2
    |=> o_rresp == RESP_ERR && o_rdata == 32'h0) else $error("unmapped read not refused");
  AST_BIT_MIN: assert property ($fell(o_tx_line) |-> !o_tx_line [*8])
    else $error("transmit bit too short");
  AST_RST_TX: assert property ($fell(i_srst) |-> o_tx_line)
    else $error("transmit line not idle after reset");
  cover property (o_bvalid && i_bready);
  cover property (o_rvalid && i_rready);
  cover property ($fell(o_tx_line));
endmodule
bind uart_stop_bits_baud_gen uart_sb_monitor #(.DATA_BITS(DATA_BITS)) u_mon (.*);
`default_nettype wire

// ===== uart_line_partner.sv
// Purpose: Remote serial device on the line side
// Assumes: Line driven in step with the clock
// Notes:   Also measures low pulses on the transmit line
`timescale 1ns/1ns
`default_nettype none
module uart_line_partner (
  input  wire logic        i_clock,   // Clock
  input  wire logic        i_go,      // Send one frame
  input  wire logic [7:0]  i_byte,    // Data, LSB first
  input  wire logic        i_stop1,   // First stop level
  input  wire logic        i_stop2,   // Second stop level
  input  wire logic [15:0] i_bitc,    // Cycles per bit
  input  wire logic        i_tx,      // Device transmit line
  output var  logic        o_line,    // Device receive line
  output var  logic [15:0] o_low_len, // Last low pulse length
  output var  logic [7:0]  o_low_cnt  // Low pulses seen
);
  // ==========
  // Frame sender and pulse meter
  logic [10:0] frame = '1;
  logic [3:0]  nbits = '0;
  logic [15:0] cyc   = '0;
  logic [15:0] lowc  = '0;
  initial begin
    o_low_len = '0;
    o_low_cnt = '0;
  end
  always @(posedge i_clock) begin
    if (i_go) begin
      frame <= {i_stop2, i_stop1, i_byte, 1'b0};
      nbits <= 4'd11;
      cyc   <= '0;
    end else if (nbits != 4'd0) begin
      cyc <= (cyc == i_bitc - 16'd1) ? '0 : cyc + 16'd1;
      if (cyc == i_bitc - 16'd1) begin
        frame <= {1'b1, frame[10:1]};
        nbits <= nbits - 4'd1;
      end
    end
    lowc <= i_tx ? '0 : lowc + 16'd1;
    if (i_tx && lowc != 16'd0) begin
      o_low_len <= lowc;
      o_low_cnt <= o_low_cnt + 8'd1;
    end
  end
  // Released line returns to idle high
  assign o_line = (nbits == 4'd0) ? 1'b1 : frame[0];
endmodule
`default_nettype wire

// ===== testbench.sv
// Purpose: Self-checking bench for stop bits and bit rate
// Assumes: Divisor 4 gives 64 clocks per bit at 16x
// Notes:   Each scenario is one task
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); end end
module testbench;
  import uart_sb_pkg::*;
  logic        i_clock = 0, i_srst = 1, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  logic        i_arvalid = 0, i_rready = 0, i_rx_line, o_tx_line, go = 0, s1 = 1, s2 = 1;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [7:0]  i_awaddr = 0, i_araddr = 0, lcnt;
  logic [31:0] i_wdata = 0, o_rdata, rv;
  logic [3:0]  i_wstrb = 4'hf;
  logic [1:0]  o_bresp, o_rresp, rs;
  logic [15:0] llen;
  int          n_errors = 0, checks_done = 0;
  always #2 i_clock = ~i_clock;
  uart_stop_bits_baud_gen DUT (.*);
  uart_line_partner peer (.i_clock, .i_go(go), .i_byte(8'ha5), .i_stop1(s1), .i_stop2(s2),
    .i_bitc(16'd64), .i_tx(o_tx_line), .o_line(i_rx_line), .o_low_len(llen), .o_low_cnt(lcnt));
  // ==========
  // Bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_awaddr <= a;
    i_wdata <= d;
    {i_awvalid, i_wvalid, i_bready} <= 3'b111;
    rs = 'x;
    for (int k = 0; k < 50; k++) begin
      @(posedge i_clock);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) begin
        rs = o_bresp;
        i_bready <= 1'b0;
        break;
      end
      if (k == 49) n_errors++;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clock);
    i_araddr <= a;
    {i_arvalid, i_rready} <= 2'b11;
    {rs, rv} = 'x;
    for (int k = 0; k < 50; k++) begin
      @(posedge i_clock);
      if (o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) begin
        {rs, rv} = {o_rresp, o_rdata};
        i_rready <= 1'b0;
        break;
      end
      if (k == 49) n_errors++;
    end
  endtask
  task automatic cfg(input logic ov, input logic [31:0] c2, input logic [15:0] baud);
    wr(ADDR_CTRL1, 32'h0);
    wr(ADDR_BAUD, {16'h0, baud});
    wr(ADDR_CTRL2, c2);
    wr(ADDR_CTRL1, 32'h200c | (32'(ov) << OVS_POS));
  endtask
  // ==========
  // Scenarios
  task automatic regs();
    rd(ADDR_BAUD);
    `CHK(rv, 32'h0)
    wr(ADDR_BAUD, 32'h1bc);
    rd(ADDR_BAUD);
    `CHK({rs, rv}, {RESP_OK, 32'h1bc})
    wr(8'h40, 32'h1);
    `CHK(rs, RESP_ERR)
    rd(8'h40);
    `CHK({rs, rv}, {RESP_ERR, 32'h0})
  endtask
  task automatic rx_case(input logic [1:0] st, input logic sc, input logic a, input logic b,
                         input logic fe, input logic early);
    cfg(1'b0, (32'(st) << STOP_POS) | (32'(sc) << SC_POS), 16'h0040);
    rd(ADDR_DATA);
    @(posedge i_clock);
    {s1, s2, go} <= {a, b, 1'b1};
    @(posedge i_clock);
    go <= 1'b0;
    repeat (660) @(posedge i_clock);
    rd(ADDR_STATUS);
    `CHK(rv[RECEIVE_NOT_EMPTY_FLAG_POS], early)
    repeat (100) @(posedge i_clock);
    rd(ADDR_STATUS);
    `CHK({rv[RECEIVE_NOT_EMPTY_FLAG_POS], rv[FE_POS]}, {1'b1, fe})
    rd(ADDR_DATA);
    `CHK(rv[7:0], 8'ha5)
    repeat (1000) @(posedge i_clock);
  endtask
  task automatic tx_case(input logic ov, input logic [31:0] c2, input logic [15:0] baud,
                         input logic [15:0] len);
    logic [7:0] n;
    cfg(ov, c2, baud);
    n = lcnt;
    wr(ADDR_DATA, 32'hfd);
    for (int k = 0; k < 2000 && lcnt !== n + 8'd2; k++) @(posedge i_clock);
    `CHK(lcnt, n + 8'd2)
    `CHK(llen, len)
    rv = '1;
    for (int k = 0; k < 300 && rv[TXBUSY_POS] !== 1'b0; k++) rd(ADDR_STATUS);
    `CHK(rv[TXBUSY_POS], 1'b0)
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge i_clock);
    i_srst <= 1'b0;
    regs();
    rx_case(STOP_ONE, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    rx_case(STOP_ONE, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    rx_case(STOP_TWO, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    rx_case(STOP_TWO, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    rx_case(STOP_ONE_HALF, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    rx_case(STOP_HALF, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    tx_case(1'b0, 32'h0, 16'h0040, 16'd64);
    tx_case(1'b1, 32'h0, 16'h0040, 16'd32);
    tx_case(1'b1, 32'h1 << SC_POS, 16'h0040, 16'd64);
    tx_case(1'b0, 32'h1 << LIN_POS, 16'h0040, 16'd64);
    tx_case(1'b0, 32'h0, 16'h0048, 16'd72);
    tx_case(1'b1, 32'h0, 16'h0044, 16'd36);
    wrap_up();
  end
  initial begin
    repeat (40000) @(posedge i_clock);
    n_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
